// ---- design/arpt_pkg.sv ----
// package: register map, field layout and carriers for the reference/converter power block
package arpt_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int RES_W = 12;
   localparam logic [ADDR_W-1:0] OFS_POWER_CTRL = 8'hB4;
   localparam logic [ADDR_W-1:0] OFS_TRIGGER = 8'hC0;
   // result and status registers are placed in the free space after the trigger
   localparam logic [ADDR_W-1:0] OFS_TEMP_LO = 8'hC4;
   localparam logic [ADDR_W-1:0] OFS_TEMP_HI = 8'hC5;
   localparam logic [ADDR_W-1:0] OFS_AIN_SEL = 8'hC6;
   localparam logic [ADDR_W-1:0] OFS_AIN_LO = 8'hC7;
   localparam logic [ADDR_W-1:0] OFS_AIN_HI = 8'hC8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'hC9;
   localparam logic [DATA_W-1:0] POWER_CTRL_RST = 8'h00;
   localparam logic [DATA_W-1:0] TRIGGER_RST = 8'h00;
   localparam int BIT_REF_ON = 1;
   localparam int BIT_CONV_ON = 0;
   localparam int BIT_TRIG = 0;
   localparam int BIT_ST_BUSY = 0;
   localparam int BIT_ST_DONE = 1;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } arpt_bus_req_s;

   typedef struct packed {
      logic done;
      logic is_temp;
      logic [4:0] channel;
      logic [RES_W-1:0] value;
   } arpt_result_s;

   typedef enum logic [1:0] {
      ARPT_IDLE,
      ARPT_START,
      ARPT_BUSY
   } arpt_state_e;
endpackage

// ---- design/arpt_top.sv ----
// register bank for reference/converter power, conversion trigger and results
`timescale 1ns/1ps
module arpt_top
   import arpt_pkg::*;
#(
   parameter int NUM_AIN = 21
)
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic ARST_N,
   // register port
   input wire arpt_pkg::arpt_bus_req_s BUS_REQ,
   output logic [arpt_pkg::DATA_W-1:0] RDATA,
   // converter core
   output logic REF_POWER_ON,
   output logic CONV_POWER_ON,
   output logic INTERNAL_CONVERSION_TRIGGER,
   input wire logic CONV_STARTED,
   input wire arpt_pkg::arpt_result_s CONV_RESULT,
   output logic CONV_BUSY
);
   import arpt_pkg::*;

   // the channel field of a result is five bits wide, so more inputs cannot be addressed
   if (NUM_AIN < 1 || NUM_AIN > 32)
   begin : g_bad_num_ain
      $error("NUM_AIN must be 1 to 32");
   end

   localparam int SEL_W = (NUM_AIN > 1) ? $clog2(NUM_AIN) : 1;

   // ******************************************************
   // register storage
   // ******************************************************
   logic [DATA_W-1:0] pwr_q, pwr_d;
   logic [DATA_W-1:0] trg_q, trg_d;
   logic [RES_W-1:0] temp_q, temp_d;
   logic [RES_W-1:0] ain_q [NUM_AIN];
   logic [RES_W-1:0] ain_d [NUM_AIN];
   logic [SEL_W-1:0] sel_q, sel_d;
   logic done_q, done_d;
   logic busy_q, busy_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   arpt_state_e state_q, state_d;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic [DATA_W-1:0] lo_byte(input logic [RES_W-1:0] v);
      lo_byte = v[DATA_W-1:0];
   endfunction

   function automatic logic [DATA_W-1:0] hi_byte(input logic [RES_W-1:0] v);
      hi_byte = {{(2*DATA_W-RES_W){1'b0}}, v[RES_W-1:DATA_W]};
   endfunction

   logic wr_trig_one;
   assign wr_trig_one = BUS_REQ.wr && hit(BUS_REQ.addr, OFS_TRIGGER) && BUS_REQ.wdata[BIT_TRIG];

   // ******************************************************
   // next-state logic
   // ******************************************************
   always_comb
   begin
      pwr_d = pwr_q;
      trg_d = trg_q;
      temp_d = temp_q;
      ain_d = ain_q;
      sel_d = sel_q;
      done_d = done_q;
      state_d = state_q;
      rdata_d = UNMAPPED_READ;

      // whole byte is storage, reserved bits included
      if (BUS_REQ.wr && hit(BUS_REQ.addr, OFS_POWER_CTRL))
      begin
         pwr_d = BUS_REQ.wdata;
      end
      if (BUS_REQ.wr && hit(BUS_REQ.addr, OFS_TRIGGER))
      begin
         // reserved bits stored; a zero in bit 0 never clears a pending start
         trg_d = {BUS_REQ.wdata[DATA_W-1:1], trg_q[BIT_TRIG] | BUS_REQ.wdata[BIT_TRIG]};
      end
      if (BUS_REQ.wr && hit(BUS_REQ.addr, OFS_AIN_SEL))
      begin
         sel_d = BUS_REQ.wdata[SEL_W-1:0];
      end
      if (BUS_REQ.rd && hit(BUS_REQ.addr, OFS_STATUS))
      begin
         done_d = 1'b0;
      end

      case (state_q)
         ARPT_IDLE:
         begin
            if (trg_q[BIT_TRIG] || wr_trig_one)
            begin
               state_d = ARPT_START;
            end
         end
         ARPT_START:
         begin
            if (CONV_STARTED)
            begin
               // a fresh write of one in the same cycle wins and queues the next run
               if (!wr_trig_one)
               begin
                  trg_d[BIT_TRIG] = 1'b0;
               end
               state_d = ARPT_BUSY;
            end
         end
         ARPT_BUSY:
         begin
            if (CONV_RESULT.done && !CONV_RESULT.is_temp
                && CONV_RESULT.channel == 5'(NUM_AIN - 1))
            begin
               state_d = ARPT_IDLE;
            end
         end
         default:
         begin
            state_d = ARPT_IDLE;
         end
      endcase
      // registered so the busy output comes straight from a flop
      busy_d = (state_d == ARPT_BUSY);

      // results latch whenever the core reports one for the temperature or a channel below NUM_AIN, set wins over a status read
      if (CONV_RESULT.done)
      begin
         done_d = 1'b1;
         if (CONV_RESULT.is_temp)
         begin
            temp_d = CONV_RESULT.value;
         end
         else if (int'(CONV_RESULT.channel) < NUM_AIN)
         begin
            ain_d[CONV_RESULT.channel] = CONV_RESULT.value;
         end
      end

      if (BUS_REQ.rd)
      begin
         case (BUS_REQ.addr)
            OFS_POWER_CTRL: rdata_d = pwr_q;
            OFS_TRIGGER: rdata_d = trg_q;
            OFS_TEMP_LO: rdata_d = lo_byte(temp_q);
            OFS_TEMP_HI: rdata_d = hi_byte(temp_q);
            OFS_AIN_SEL: rdata_d = DATA_W'(sel_q);
            OFS_AIN_LO: rdata_d = (int'(sel_q) < NUM_AIN) ? lo_byte(ain_q[sel_q]) : UNMAPPED_READ;
            OFS_AIN_HI: rdata_d = (int'(sel_q) < NUM_AIN) ? hi_byte(ain_q[sel_q]) : UNMAPPED_READ;
            OFS_STATUS:
            begin
               rdata_d = UNMAPPED_READ;
               rdata_d[BIT_ST_BUSY] = (state_q != ARPT_IDLE);
               rdata_d[BIT_ST_DONE] = done_q;
            end
            default: rdata_d = UNMAPPED_READ;
         endcase
      end
   end

   // ******************************************************
   // registers
   // ******************************************************
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         pwr_q <= POWER_CTRL_RST;
         trg_q <= TRIGGER_RST;
         temp_q <= '0;
         for (int i = 0; i < NUM_AIN; i++)
         begin
            ain_q[i] <= '0;
         end
         sel_q <= '0;
         done_q <= 1'b0;
         busy_q <= 1'b0;
         rdata_q <= '0;
         state_q <= ARPT_IDLE;
      end
      else
      begin
         pwr_q <= pwr_d;
         trg_q <= trg_d;
         temp_q <= temp_d;
         ain_q <= ain_d;
         sel_q <= sel_d;
         done_q <= done_d;
         busy_q <= busy_d;
         rdata_q <= rdata_d;
         state_q <= state_d;
      end
   end

   // ******************************************************
   // outputs
   // ******************************************************
   assign RDATA = rdata_q;
   assign REF_POWER_ON = pwr_q[BIT_REF_ON];
   assign CONV_POWER_ON = pwr_q[BIT_CONV_ON];
   assign INTERNAL_CONVERSION_TRIGGER = trg_q[BIT_TRIG];
   assign CONV_BUSY = busy_q;
endmodule

// ---- verif/arpt_top_sva.sv ----
// checker for the power and trigger register bank
`timescale 1ns/1ps
module arpt_top_sva
   import arpt_pkg::*;
#(
   parameter int NUM_AIN = 21
)
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic ARST_N,
   // register port and converter core
   input wire arpt_pkg::arpt_bus_req_s BUS_REQ,
   input wire logic [arpt_pkg::DATA_W-1:0] RDATA,
   input wire logic REF_POWER_ON,
   input wire logic CONV_POWER_ON,
   input wire logic INTERNAL_CONVERSION_TRIGGER,
   input wire logic CONV_STARTED,
   input wire arpt_pkg::arpt_result_s CONV_RESULT,
   input wire logic CONV_BUSY
);
   // ****
   // properties
   // ****
   logic pw;
   logic tw;
   logic trg;
   assign pw = BUS_REQ.wr && BUS_REQ.addr == OFS_POWER_CTRL;
   assign tw = BUS_REQ.wr && BUS_REQ.addr == OFS_TRIGGER;
   assign trg = INTERNAL_CONVERSION_TRIGGER;
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!ARST_N);
   reset_quiet_a: assert property (
      !$past(ARST_N) |-> !REF_POWER_ON && !CONV_POWER_ON && !trg)
      else $error("outputs not low after reset");
   power_write_a: assert property (
      pw |=> {REF_POWER_ON, CONV_POWER_ON} == $past(BUS_REQ.wdata[1:0]))
      else $error("power outputs do not follow write");
   power_hold_a: assert property (
      !pw |=> $stable({REF_POWER_ON, CONV_POWER_ON}))
      else $error("power outputs changed without write");
   power_read_a: assert property (
      BUS_REQ.rd && BUS_REQ.addr == OFS_POWER_CTRL
      |=> RDATA[1:0] == {REF_POWER_ON, CONV_POWER_ON})
      else $error("power read back differs");
   trig_set_a: assert property (
      tw && BUS_REQ.wdata[0] |=> trg)
      else $error("trigger not set");
   trig_keep_a: assert property (
      tw && !BUS_REQ.wdata[0] && trg && !CONV_STARTED && !$past(CONV_STARTED) |=> trg)
      else $error("zero write disturbed trigger");
   // a started pulse before the start state is not a clear condition, hence the past term
   trig_clear_a: assert property (
      $past(trg) && trg && CONV_STARTED && !BUS_REQ.wr |-> ##[1:2] !trg)
      else $error("trigger did not self-clear");
   busy_rise_a: assert property (
      $fell(trg) |-> CONV_BUSY)
      else $error("trigger cleared without run");
   busy_end_a: assert property (
      CONV_BUSY && CONV_RESULT.done && !CONV_RESULT.is_temp
      && CONV_RESULT.channel == 5'(NUM_AIN - 1) |=> !CONV_BUSY)
      else $error("run not ended on last result");
endmodule

bind arpt_top arpt_top_sva #(.NUM_AIN(NUM_AIN)) i_sva (.CLOCK(CLOCK), .ARST_N(ARST_N),
   .BUS_REQ(BUS_REQ), .RDATA(RDATA), .REF_POWER_ON(REF_POWER_ON),
   .CONV_POWER_ON(CONV_POWER_ON), .INTERNAL_CONVERSION_TRIGGER(INTERNAL_CONVERSION_TRIGGER),
   .CONV_STARTED(CONV_STARTED), .CONV_RESULT(CONV_RESULT), .CONV_BUSY(CONV_BUSY));

// ---- verif/arpt_top_bench.sv ----
// self-checking bench for the power and trigger register bank
`timescale 1ns/1ps
module arpt_top_bench;
   import arpt_pkg::*;
   // ****
   // stimulus and checks
   // ****
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   arpt_bus_req_s req = '0;
   arpt_result_s res = '0;
   logic started = 1'b0;
   logic [7:0] rdata;
   logic ref_on, conv_on, trig, busy;
   int err_total = 0;
   int checks_done = 0;
   // address, write data, read-back value; the last row is unmapped
   logic [23:0] rows [6] = '{24'hB4FFFF, 24'hB40000, 24'hB40101, 24'hB40202, 24'hC0FEFE,
      24'h105A00};
   always #12.5 clk = ~clk;
   arpt_top i_dut (.CLOCK(clk), .ARST_N(rst_n), .BUS_REQ(req), .RDATA(rdata),
      .REF_POWER_ON(ref_on), .CONV_POWER_ON(conv_on), .INTERNAL_CONVERSION_TRIGGER(trig),
      .CONV_STARTED(started), .CONV_RESULT(res), .CONV_BUSY(busy));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ends 1 ns past the taking edge so outputs have settled
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic summarize;
      $display("checks %0d, errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_POWER_CTRL, 8'h00);
      rd(OFS_TRIGGER, 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
         if (rows[i][23:16] == 8'hB4)
            chk({6'h00, ref_on, conv_on}, {6'h00, rows[i][9:8]});
      end
      wr(OFS_TRIGGER, 8'h01);
      chk({7'h00, trig}, 8'h01);
      wr(OFS_TRIGGER, 8'h00);
      chk({7'h00, trig}, 8'h01);
      @(posedge clk);
      started <= 1'b1;
      repeat (3) @(posedge clk);
      started <= 1'b0;
      #1 chk({6'h00, busy, trig}, 8'h02);
      rd(OFS_TRIGGER, 8'h00);
      wr(OFS_AIN_SEL, 8'h14);
      @(posedge clk);
      res <= '{1'b1, 1'b1, 5'h00, 12'hABC};
      @(posedge clk);
      res <= '{1'b1, 1'b0, 5'h14, 12'h123};
      @(posedge clk);
      res.done <= 1'b0;
      #1 chk({7'h00, busy}, 8'h00);
      rd(OFS_TEMP_LO, 8'hBC);
      rd(OFS_TEMP_HI, 8'h0A);
      rd(OFS_AIN_LO, 8'h23);
      rd(OFS_AIN_HI, 8'h01);
      rd(OFS_STATUS, 8'h02);
      rd(OFS_STATUS, 8'h00);
      wr(OFS_POWER_CTRL, 8'h03);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      #1 chk({6'h00, ref_on, conv_on}, 8'h00);
      rd(OFS_POWER_CTRL, 8'h00);
      summarize();
   end
   // the sequence needs about 80 cycles, 2 us; six times that is ample
   initial
   begin
      #12us;
      err_total++;
      summarize();
   end
endmodule
